/* design/optical_link_mode_supervisor.sv */
// Operating mode selection and optical link supervision
module optical_link_mode_supervisor
    import link_supervisor_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic band_select_in,
    input wire logic [LEVEL_W-1:0] rx_level_in,
    input wire logic [LEVEL_W-1:0] remote_level_in,
    input wire logic remote_level_valid_in,
    input wire logic mode_button_in,
    input wire logic link_fault_in,
    output logic switching_output_one_out,
    output logic [BAR_SEGMENTS-1:0] rx_level_bar_out,
    output logic [LEVEL_W-1:0] level_report_out,
    output logic level_report_valid_out,
    output logic standard_transfer_led_out,
    output logic hand_tuning_led_out,
    output logic align_only_led_out,
    output logic pointer_beam_led_out,
    output logic tally_green_out,
    output logic tally_red_out,
    output logic link_active_out,
    output logic forward_enable_out,
    output logic pointer_laser_on_out,
    output logic tx_band_out
);

    ////////////////////////////////////////////////////////////////////////
    level_path_if own_path ();
    level_path_if remote_path ();

    level_classifier own_cls (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .lvl(own_path.cls)
    );

    level_classifier remote_cls (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .lvl(remote_path.cls)
    );

    assign own_path.level = rx_level_in;
    assign remote_path.level = remote_level_in;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        op_mode_type mode;
        logic button_prev;
        tally_type tally;
        logic link_up;
        logic warning;
        logic [BAR_SEGMENTS-1:0] bar;
        logic [LEVEL_W-1:0] report;
        logic report_valid;
        logic band;
        logic [SEG_W-1:0] remote_seg;
    } sup_state_type;

    sup_state_type state_ff;
    sup_state_type nxt_state;

    logic [SEG_W-1:0] own_seg;
    logic [SEG_W-1:0] keep_seg;
    logic [SEG_W-1:0] shown_seg;
    logic link_ok;

    assign own_seg = own_path.segments;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.button_prev = mode_button_in;
        if (mode_button_in && !state_ff.button_prev) begin
            unique case (state_ff.mode)
                standard_transfer_mode: nxt_state.mode = hand_tuning_mode;
                hand_tuning_mode: nxt_state.mode = align_only_mode;
                align_only_mode: nxt_state.mode = pointer_beam_mode;
                pointer_beam_mode: nxt_state.mode = interruption_tally_mode;
                interruption_tally_mode: nxt_state.mode = standard_transfer_mode;
                default: nxt_state.mode = standard_transfer_mode;
            endcase
        end

        keep_seg = LOWEST_ORANGE_SEG;
        if (state_ff.mode == hand_tuning_mode) begin
            keep_seg = LOWEST_GREEN_SEG;
        end

        link_ok = !link_fault_in && (own_seg >= keep_seg);
        nxt_state.link_up = link_ok;

        nxt_state.warning = own_seg < LOWEST_GREEN_SEG;

        // partner level shown in align mode
        if (remote_level_valid_in) begin
            nxt_state.remote_seg = remote_path.segments;
        end
        shown_seg = own_seg;
        if (state_ff.mode == align_only_mode) begin
            shown_seg = state_ff.remote_seg;
        end
        for (int i = 0; i < BAR_SEGMENTS; i++) begin
            nxt_state.bar[i] = shown_seg > SEG_W'(i);
        end

        nxt_state.report = rx_level_in;
        nxt_state.report_valid = (state_ff.mode == align_only_mode);

        nxt_state.band = band_select_in ? BAND_SECOND : BAND_FIRST;

        // tally dark outside diagnostic
        // Next mode, so green lights with entry and no edge has no lit indicator
        if (nxt_state.mode != interruption_tally_mode) begin
            nxt_state.tally = tally_dark;
        end else begin
            unique case (state_ff.tally)
                tally_dark: nxt_state.tally = tally_green;
                tally_green: nxt_state.tally = state_ff.link_up ? tally_green : tally_red;
                tally_red: nxt_state.tally = tally_red;
                default: nxt_state.tally = tally_dark;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff <= '{mode: standard_transfer_mode, tally: tally_dark, default: '0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // warning on switching output
    assign switching_output_one_out = state_ff.warning;
    assign rx_level_bar_out = state_ff.bar;
    assign level_report_out = state_ff.report;
    assign level_report_valid_out = state_ff.report_valid;
    assign standard_transfer_led_out = state_ff.mode == standard_transfer_mode;
    assign hand_tuning_led_out = state_ff.mode == hand_tuning_mode;
    assign align_only_led_out = state_ff.mode == align_only_mode;
    assign pointer_beam_led_out = state_ff.mode == pointer_beam_mode;
    assign tally_green_out = state_ff.tally == tally_green;
    assign tally_red_out = state_ff.tally == tally_red;
    assign link_active_out = state_ff.link_up;
    assign forward_enable_out = state_ff.link_up && (state_ff.mode != align_only_mode);
    assign pointer_laser_on_out = state_ff.mode == pointer_beam_mode;
    assign tx_band_out = state_ff.band;

endmodule // optical_link_mode_supervisor

/* design/link_supervisor_pkg.sv */
// Package with level classes, modes and constants of the link supervisor
package link_supervisor_pkg;

    localparam int LEVEL_W = 8;
    localparam int BAR_SEGMENTS = 8;
    localparam int SEG_W = 4;
    // Bar layout: segments 1..2 red, 3..4 orange, 5..8 green
    localparam logic [SEG_W-1:0] LOWEST_ORANGE_SEG = 4'h3;
    localparam logic [SEG_W-1:0] LOWEST_GREEN_SEG = 4'h5;
    // Raw level thresholds per segment, segment n lit when level >= n*SEG_STEP
    localparam logic [LEVEL_W-1:0] SEG_STEP = 8'h1e;
    localparam logic [SEG_W-1:0] SEG_RESET = 4'h0;
    localparam logic BAND_FIRST = 1'b0;
    localparam logic BAND_SECOND = 1'b1;

    typedef enum logic [2:0] {
        standard_transfer_mode,
        hand_tuning_mode,
        align_only_mode,
        pointer_beam_mode,
        interruption_tally_mode
    } op_mode_type;

    typedef enum logic [1:0] {
        tally_dark,
        tally_green,
        tally_red
    } tally_type;

endpackage : link_supervisor_pkg

/* design/level_path_if.sv */
// Interface carrying the classified level between the supervisor modules
interface level_path_if;
    import link_supervisor_pkg::*;
    logic [LEVEL_W-1:0] level;
    logic [SEG_W-1:0] segments;

    modport src (output level, input segments);
    modport cls (input level, output segments);
endinterface : level_path_if

/* design/level_classifier.sv */
// Registered classifier from raw level to lit bar segment count
module level_classifier
    import link_supervisor_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    level_path_if.cls lvl
);

    typedef struct packed {
        logic [SEG_W-1:0] segments;
    } cls_state_type;

    cls_state_type state_ff;
    cls_state_type nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.segments = SEG_RESET;
        for (int i = 1; i <= BAR_SEGMENTS; i++) begin
            if (lvl.level >= LEVEL_W'(i * SEG_STEP)) begin
                nxt_state.segments = SEG_W'(i);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign lvl.segments = state_ff.segments;

endmodule // level_classifier

/* dv/optical_link_mode_supervisor_checker.sv */
// Port checker for the link supervisor
module link_supervisor_checker
    import link_supervisor_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [LEVEL_W-1:0] rx_level_in,
    input wire logic mode_button_in,
    input wire logic link_fault_in,
    input wire logic switching_output_one_out,
    input wire logic standard_transfer_led_out,
    input wire logic hand_tuning_led_out,
    input wire logic align_only_led_out,
    input wire logic pointer_beam_led_out,
    input wire logic tally_green_out,
    input wire logic tally_red_out,
    input wire logic link_active_out,
    input wire logic forward_enable_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Two register stages need three quiet samples
    sequence settled_s;
        (!link_fault_in && $stable({rx_level_in, mode_button_in}) && $past(rst_n_in, 4))[*3];
    endsequence
    sequence press_s;
        $rose(mode_button_in);
    endsequence
    warn_level_a: assert property (settled_s ##0 !align_only_led_out
        |-> switching_output_one_out == (rx_level_in < 8'h96)) else $error("warning level wrong");
    link_keep_a: assert property (settled_s ##0 !align_only_led_out && !tally_red_out
        && (standard_transfer_led_out || hand_tuning_led_out)
        |-> link_active_out == (rx_level_in >= (hand_tuning_led_out ? 8'h96 : 8'h5a))) else $error("link state wrong");
    fault_drop_a: assert property (link_fault_in[*3] |-> !link_active_out) else $error("link up in fault");
    one_mode_a: assert property ($onehot({standard_transfer_led_out, hand_tuning_led_out,
        align_only_led_out, pointer_beam_led_out, tally_green_out, tally_red_out})) else $error("modes not one");
    mode_step_a: assert property (press_s ##0 standard_transfer_led_out
        |=> hand_tuning_led_out) else $error("no mode advance");
    tally_enter_a: assert property (press_s ##0 pointer_beam_led_out
        |=> tally_green_out) else $error("tally not green");
    btn_hold_a: assert property (mode_button_in && $past(mode_button_in)
        |=> $stable({standard_transfer_led_out, hand_tuning_led_out, align_only_led_out})) else $error("held advance");
    fwd_align_a: assert property (forward_enable_out
        |-> link_active_out && !align_only_led_out) else $error("forward wrong");
    red_set_a: assert property (tally_green_out && !link_active_out && !$rose(mode_button_in)
        |=> tally_red_out) else $error("red not set");
    red_hold_a: assert property (tally_red_out && !$rose(mode_button_in)
        |=> tally_red_out) else $error("red not held");
endmodule // link_supervisor_checker

bind optical_link_mode_supervisor link_supervisor_checker chk_u (.*);

/* dv/partner_unit.sv */
// Opposing transceiver model of the pair
module partner_unit
    import link_supervisor_pkg::*;
(
    input wire logic clk_in,
    input wire logic tx_band_in,
    input wire logic report_valid_in,
    input wire logic [LEVEL_W-1:0] own_level_in,
    output logic band_out,
    output logic [LEVEL_W-1:0] level_out,
    output logic valid_out
);
    timeunit 1ns;
    timeprecision 1ns;
    assign band_out = ~tx_band_in;
    // level sent in align mode; inverse when idle
    always_ff @(posedge clk_in) begin
        valid_out <= report_valid_in;
        level_out <= report_valid_in ? own_level_in : ~own_level_in;
    end
endmodule // partner_unit

/* dv/testbench.sv */
// Self-checking bench for the link supervisor
module testbench
    import link_supervisor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0, rst_n_in = 1'b0, band_select_in = 1'b0, mode_button_in = 1'b0, link_fault_in = 1'b0;
    logic [7:0] rx_level_in = 8'h00, peer_level = 8'h00, remote_level_in, rx_level_bar_out, level_report_out;
    logic remote_level_valid_in, switching_output_one_out, level_report_valid_out, standard_transfer_led_out;
    logic hand_tuning_led_out, align_only_led_out, pointer_beam_led_out, tally_green_out, tally_red_out;
    logic link_active_out, forward_enable_out, pointer_laser_on_out, tx_band_out, peer_band;
    logic [7:0] sweep [9] = '{8'h00, 8'h1d, 8'h1e, 8'h59, 8'h5a, 8'h95, 8'h96, 8'hef, 8'hf0};
    int n_fail = 0, num_checks = 0, cyc = 0;
    wire [7:0] modes = {2'h0, standard_transfer_led_out, hand_tuning_led_out, align_only_led_out,
        pointer_beam_led_out, tally_green_out, tally_red_out};
    wire [7:0] flags = {3'h0, switching_output_one_out, link_active_out, forward_enable_out,
        pointer_laser_on_out, level_report_valid_out};
    optical_link_mode_supervisor dut_u (.*);
    partner_unit peer_u (.clk_in(clk_in), .tx_band_in(tx_band_out), .report_valid_in(level_report_valid_out),
        .own_level_in(peer_level), .band_out(peer_band), .level_out(remote_level_in), .valid_out(remote_level_valid_in));
    initial forever #50 clk_in = ~clk_in;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #10;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Selector presses keep a low sample between them
    task automatic press(input int hold);
        mode_button_in = 1'b1;
        tick(hold);
        mode_button_in = 1'b0;
        tick(3);
    endtask
    task automatic lvl(input logic [7:0] l, input logic f);
        rx_level_in = l;
        link_fault_in = f;
        tick(4);
    endtask
    function automatic logic [7:0] bar_of(input logic [7:0] l);
        for (int i = 0; i < 8; i++)
            bar_of[i] = l >= SEG_STEP * (i + 1);
    endfunction
    task automatic complete_run();
        if (n_fail == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        tick(5);
        rst_n_in = 1'b1;
        band_select_in = 1'b1;
        tick(2);
        chk(modes, 8'h20);
        chk({6'h00, tx_band_out, peer_band}, 8'h02);
        foreach (sweep[k]) begin
            lvl(sweep[k], 1'b0);
            chk(rx_level_bar_out, bar_of(sweep[k]));
            chk(flags, {3'h0, sweep[k] < 8'h96, {2{sweep[k] >= 8'h5a}}, 2'h0});
        end
        lvl(8'hff, 1'b1);
        chk(flags, 8'h00);
        lvl(8'hff, 1'b0);
        chk(flags, 8'h0c);
        press(1);
        chk(modes, 8'h10);
        lvl(8'h78, 1'b0);
        chk(flags, 8'h10);
        peer_level = 8'hf0;
        press(1);
        lvl(8'h5a, 1'b0);
        chk(modes, 8'h08);
        chk(rx_level_bar_out, 8'hff);
        chk(level_report_out, 8'h5a);
        chk(flags & 8'h0f, 8'h09);
        press(4);
        chk(modes, 8'h04);
        chk(flags & 8'h02, 8'h02);
        lvl(8'hff, 1'b0);
        press(1);
        chk(modes, 8'h02);
        lvl(8'hff, 1'b1);
        chk(modes, 8'h01);
        lvl(8'hff, 1'b0);
        chk(modes, 8'h01);
        chk(flags, 8'h0c);
        press(1);
        chk(modes, 8'h20);
        complete_run();
    end
endmodule // testbench
